// ### include/pwr_seq_pkg.sv
// Shared constants and types for the power-up reset sequencer.
// Assumes a single 25 MHz system clock and a synchronous, active-low reset.
package pwr_seq_pkg;

	// System clock rate and the lock interval in milliseconds
	localparam longint unsigned CLOCK_HZ     = 64'h17D7840;
	localparam longint unsigned LOCK_WAIT_MS = 64'h3C;

	// Least wait rounds up to whole cycles
	localparam longint unsigned LOCK_WAIT_CYCLES =
		(LOCK_WAIT_MS * CLOCK_HZ + 64'h3E7) / 64'h3E8;

	// Counter width holds the full 60 ms count
	localparam int LOCK_CNT_W = 21;

	// Longest wait for the mirror array to report parked before forcing reset
	localparam int PARK_CNT_W = 9;
	localparam logic [PARK_CNT_W-1:0] PARK_TIMEOUT_CYCLES = 9'h100;

	// Number of non-processor clock domains that firmware releases
	localparam int OTHER_CLK_N = 4;
	localparam logic [OTHER_CLK_N-1:0] OTHER_CLK_RESET_VALUE = 4'h0;

	// Sequencer states
	typedef enum logic [2:0] {
		ST_OFF    = 3'b000,  // Power sense low, everything held
		ST_LOCK   = 3'b001,  // Primary PLL locking
		ST_RUN    = 3'b010,  // Normal power mode
		ST_PARK   = 3'b011,  // Parking mirrors before a supply drop
		ST_SYSRST = 3'b100   // System reset with power still applied
	} seq_state_type;

endpackage

// ### rtl/lock_delay_timer.sv
// Lock-interval timer: counts while run is high, restarts when run drops.
// Assumes run is held high for the whole interval by the sequencer.
`timescale 1ns/1ps
`default_nettype none
module lock_delay_timer #(
	parameter int unsigned CYCLES = 32'h16E360
) (
	// Clock and reset
	input  wire logic                               clock,
	input  wire logic                               rst_n,
	// Control and status
	input  wire logic                               run,
	output logic                                    done
);
	import pwr_seq_pkg::*;

	localparam logic [pwr_seq_pkg::LOCK_CNT_W-1:0] LAST = LOCK_CNT_W'(CYCLES - 32'h1);

	logic [LOCK_CNT_W-1:0] count_r;
	logic [LOCK_CNT_W-1:0] count_nxt;

	// Done as a level so a late consumer cannot miss it
	assign done      = run && (count_r == LAST);
	assign count_nxt = (run && !done) ? count_r + LOCK_CNT_W'(1) : count_r;

	// Dropping run restarts the interval from zero
	always_ff @(posedge clock) begin
		if (!rst_n || !run) begin
			count_r <= '0;
		end else begin
			count_r <= count_nxt;
		end
	end

	property p_count_step;
		@(posedge clock) disable iff (!rst_n)
		(run && !done) |=> (!run || count_r == $past(count_r) + LOCK_CNT_W'(1));
	endproperty
	a_count_step: assert property (p_count_step)
		else $error("lock timer did not advance by one");

endmodule
`default_nettype wire

// ### rtl/power_up_reset_sequencer.sv
// Power-up and system reset sequencer of the mirror-array controller.
// Assumes power_on_sense and supply_good_warning come from an external power
// monitor synchronous to clock, and that firmware drives the release inputs.
//
// Functional notes
// - While power-on sense is low, hold system reset and tristate all pins.
// - Release the primary PLL reset on power-on sense rising edge, never earlier.
// - Keep internal system reset for 60 ms after that edge for PLL lock.
// - At the end of the lock wait release internal resets; processor boots.
// - After power-up enter normal mode: processor clocks full rate, resets released.
// - Other clocks start disabled with resets asserted until processor releases them.
// - Apply the same clock and reset defaults on every system reset under power.
// - On supply-good warning, park the mirror array, then force system reset.
// - For revision B or later mirror arrays ignore the supply-good warning.
// - Primary PLL is reset only by power-up; other resets leave it running.
`timescale 1ns/1ps
`default_nettype none
module power_up_reset_sequencer #(
	parameter int unsigned LOCK_CYCLES = 32'(pwr_seq_pkg::LOCK_WAIT_CYCLES)
) (
	// Clock and reset
	input  wire logic                                  clock,
	input  wire logic                                  rst_n,
	// Power monitor
	input  wire logic                                  power_on_sense,
	input  wire logic                                  supply_good_warning,
	// Board strap: mirror array is revision B or later
	input  wire logic                                  mirrorRevB,
	// System reset sources while power stays applied (e.g. watchdog)
	input  wire logic                                  sysResetReq,
	// Mirror array park handshake
	output logic                                       parkRequest,
	input  wire logic                                  parkDone,
	// Firmware release of non-processor clock domains, one pulse per bit
	input  wire logic [pwr_seq_pkg::OTHER_CLK_N-1:0]   otherRelease,
	// Reset and clock controls
	output logic                                       primary_pll_reset,
	output logic                                       systemReset,
	output logic                                       ioDriveEnable,
	output logic                                       normalPowerMode,
	output logic                                       cpuClockEnable,
	output logic                                       cpuClockFullRate,
	output logic                                       cpuReset,
	output logic [pwr_seq_pkg::OTHER_CLK_N-1:0]        otherClockEnable,
	output logic [pwr_seq_pkg::OTHER_CLK_N-1:0]        otherReset,
	output logic                                       bootStart
);
	import pwr_seq_pkg::*;

	localparam int ParkBound = 260;

	seq_state_type             state_r;
	seq_state_type             state_nxt;
	logic                      senseLast_r;
	logic                      revB_r;
	logic                      lockDone;
	logic                      senseRise;
	logic                      warnActive;
	logic                      parkTimeout;
	logic [PARK_CNT_W-1:0]     parkCount_r;
	logic [OTHER_CLK_N-1:0]    otherEn_r;
	logic [OTHER_CLK_N-1:0]    otherEn_nxt;
	logic                      pllReset_r;
	logic                      pllReset_nxt;
	logic                      inRun;
	logic                      inRunNxt;
	logic                      bootStart_r;

	// Edge detect; the last-sense flop resets low so a sense already high at
	// reset release still counts as a rising edge rather than deadlocking
	assign senseRise   = power_on_sense && !senseLast_r;
	// Revision B arrays cannot trust the warning, so it is masked out
	assign warnActive  = supply_good_warning && !revB_r;
	assign parkTimeout = (parkCount_r == PARK_TIMEOUT_CYCLES);

	// Lock interval timer runs only in the lock state
	lock_delay_timer #(
		.CYCLES (LOCK_CYCLES)
	) u_lock_timer (
		.clock (clock),
		.rst_n (rst_n),
		.run   (state_r == ST_LOCK),
		.done  (lockDone)
	);

	// Next state; loss of power sense overrides everything
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_OFF: begin
				if (senseRise) begin
					state_nxt = ST_LOCK;
				end
			end
			ST_LOCK: begin
				if (lockDone) begin
					state_nxt = ST_RUN;
				end
			end
			ST_RUN: begin
				if (warnActive) begin
					state_nxt = ST_PARK;
				end else if (sysResetReq) begin
					state_nxt = ST_SYSRST;
				end
			end
			ST_PARK: begin
				if (parkDone || parkTimeout) begin
					state_nxt = ST_SYSRST;
				end
			end
			ST_SYSRST: begin
				// Leave only once every reset source has gone away
				if (!sysResetReq && !warnActive) begin
					state_nxt = ST_RUN;
				end
			end
			default: begin
				state_nxt = ST_OFF;
			end
		endcase
		if (!power_on_sense) begin
			state_nxt = ST_OFF;
		end
	end

	// Primary PLL stays in reset until the sense edge, then only power loss resets it
	assign pllReset_nxt = (state_nxt == ST_OFF);

	// Run decode drives normal mode and the processor release
	assign inRunNxt = (state_nxt == ST_RUN) || (state_nxt == ST_PARK);

	// Other clock domains: set by firmware in normal mode, cleared by any reset
	assign otherEn_nxt = inRunNxt ? (otherEn_r | otherRelease)
	                              : OTHER_CLK_RESET_VALUE;

	// State, edge and strap registers
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_r     <= ST_OFF;
			senseLast_r <= 1'b0;
			revB_r      <= mirrorRevB;
		end else begin
			state_r     <= state_nxt;
			senseLast_r <= power_on_sense;
		end
	end

	// Park wait counter, bounded so a silent array cannot block the reset
	always_ff @(posedge clock) begin
		if (!rst_n || state_r != ST_PARK) begin
			parkCount_r <= '0;
		end else if (!parkTimeout) begin
			parkCount_r <= parkCount_r + PARK_CNT_W'(1);
		end
	end

	// Output flops, updated from the next state so they track state_r
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pllReset_r  <= 1'b1;
			inRun       <= 1'b0;
			otherEn_r   <= OTHER_CLK_RESET_VALUE;
			bootStart_r <= 1'b0;
		end else begin
			pllReset_r  <= pllReset_nxt;
			inRun       <= inRunNxt;
			otherEn_r   <= otherEn_nxt;
			bootStart_r <= (state_r == ST_LOCK) && (state_nxt == ST_RUN);
		end
	end

	// Reset and clock outputs
	assign primary_pll_reset = pllReset_r;
	assign systemReset       = !inRun;
	assign ioDriveEnable     = inRun;
	assign normalPowerMode   = inRun;
	assign cpuClockEnable    = inRun;
	assign cpuClockFullRate  = inRun;
	assign cpuReset          = !inRun;
	assign otherClockEnable  = otherEn_r;
	assign otherReset        = ~otherEn_r;
	assign parkRequest       = (state_r == ST_PARK);
	assign bootStart         = bootStart_r;

	// Low sense forces reset and tristate by the next edge
	property p_sense_low_holds;
		@(posedge clock) disable iff (!rst_n)
		!power_on_sense |=> (systemReset && !ioDriveEnable && primary_pll_reset);
	endproperty
	a_sense_low_holds: assert property (p_sense_low_holds)
		else $error("reset or tristate not held while sense low");

	// PLL leaves reset only right after a sense rising edge
	property p_pll_release_on_edge;
		@(posedge clock) disable iff (!rst_n)
		$fell(primary_pll_reset) |-> $past(senseRise);
	endproperty
	a_pll_release_on_edge: assert property (p_pll_release_on_edge)
		else $error("primary PLL released without a sense edge");

	// System reset held throughout the lock wait
	property p_lock_holds_reset;
		@(posedge clock) disable iff (!rst_n)
		(state_r == ST_LOCK) |-> (systemReset && cpuReset && !primary_pll_reset);
	endproperty
	a_lock_holds_reset: assert property (p_lock_holds_reset)
		else $error("reset dropped during lock wait");

	// Lock done releases resets one edge later with a boot pulse
	property p_release_after_lock;
		@(posedge clock) disable iff (!rst_n)
		(state_r == ST_LOCK && lockDone && power_on_sense)
			|=> (!systemReset && !cpuReset && bootStart) ##1 !bootStart;
	endproperty
	a_release_after_lock: assert property (p_release_after_lock)
		else $error("resets not released at end of lock wait");

	// Normal mode runs processor clocks at full rate
	property p_normal_mode;
		@(posedge clock) disable iff (!rst_n)
		(state_r == ST_RUN) |-> (normalPowerMode && cpuClockEnable && cpuClockFullRate);
	endproperty
	a_normal_mode: assert property (p_normal_mode)
		else $error("normal power mode not applied");

	// Other clocks turn on only from a firmware release in normal mode
	property p_other_needs_release;
		@(posedge clock) disable iff (!rst_n)
		((otherEn_r & ~$past(otherEn_r)) != '0) |->
			(($past(otherRelease) & otherEn_r & ~$past(otherEn_r)) != '0) && inRun;
	endproperty
	a_other_needs_release: assert property (p_other_needs_release)
		else $error("other clock enabled without release");

	// Every system reset restores the defaults
	property p_reset_defaults;
		@(posedge clock) disable iff (!rst_n)
		(state_r == ST_SYSRST) |-> (otherClockEnable == '0 && otherReset == '1 && cpuReset);
	endproperty
	a_reset_defaults: assert property (p_reset_defaults)
		else $error("defaults not applied in system reset");

	// Warning in normal mode parks, then reset follows within the timeout
	property p_warn_parks;
		@(posedge clock) disable iff (!rst_n)
		(state_r == ST_RUN && warnActive && power_on_sense) |=>
			parkRequest ##[1:ParkBound] systemReset;
	endproperty
	a_warn_parks: assert property (p_warn_parks)
		else $error("warning did not park and reset");

	// Revision B arrays never park on the warning
	property p_revb_ignores_warn;
		@(posedge clock) disable iff (!rst_n)
		(state_r == ST_RUN && revB_r) |=> !parkRequest;
	endproperty
	a_revb_ignores_warn: assert property (p_revb_ignores_warn)
		else $error("warning acted on with revision B array");

	// PLL keeps running through non-power resets
	property p_pll_keeps_running;
		@(posedge clock) disable iff (!rst_n)
		(!primary_pll_reset && power_on_sense) |=> !primary_pll_reset;
	endproperty
	a_pll_keeps_running: assert property (p_pll_keeps_running)
		else $error("primary PLL reset without power loss");

	// Losing sense returns to the off state at once
	property p_sense_loss_restarts;
		@(posedge clock) disable iff (!rst_n)
		(!power_on_sense && state_r != ST_OFF) |=> (state_r == ST_OFF);
	endproperty
	a_sense_loss_restarts: assert property (p_sense_loss_restarts)
		else $error("sense loss did not restart sequence");

endmodule
`default_nettype wire

// ### tb/power_monitor_model.sv
// External power monitor and sequencing hardware seen by the reset sequencer.
// Assumes bench commands change just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module power_monitor_model #(
	parameter int PARK_DLY = 3
) (
	// Clock
	input  wire logic clock,
	// Bench commands
	input  wire logic powerCmd,
	input  wire logic warnCmd,
	input  wire logic parkMute,
	// Device side
	input  wire logic parkRequest,
	output logic      power_on_sense,
	output logic      supply_good_warning,
	output logic      parkDone
);
	logic [2:0] railsOn_r;
	int         parkCnt_r;

	initial begin
		railsOn_r = 3'h0;
		parkCnt_r = 0;
		power_on_sense = 1'b0;
		supply_good_warning = 1'b0;
		parkDone = 1'b0;
	end

	// Core rail first, then I/O, then 1.8V; sense rises only once all are up
	always @(posedge clock) begin
		if (!powerCmd) begin
			railsOn_r <= 3'h0;
			power_on_sense <= 1'b0;
		end else begin
			railsOn_r <= {railsOn_r[1:0], 1'b1};
			power_on_sense <= &railsOn_r;
		end
		supply_good_warning <= warnCmd;
		// Mirrors report parked a few cycles after the request, never instantly
		parkCnt_r <= parkRequest ? parkCnt_r + 1 : 0;
		// A muted array never answers, which exercises the park timeout
		parkDone <= parkRequest && !parkMute && (parkCnt_r >= PARK_DLY);
	end
endmodule
`default_nettype wire

// ### tb/power_up_reset_sequencer_tb_top.sv
// Self-checking bench for the power-up reset sequencer.
// Assumes a shortened lock wait of L cycles and the monitor model beside it.
`timescale 1ns/1ps
`default_nettype none
module power_up_reset_sequencer_tb_top;
	import pwr_seq_pkg::*;
	localparam int L = 20;
	typedef struct packed {logic [3:0] rel; logic [3:0] en;} row_type;
	row_type rows [4] = '{'{4'h1, 4'h1}, '{4'h4, 4'h5}, '{4'h8, 4'hD}, '{4'h2, 4'hF}};
	logic clock, rst_n, powerCmd, warnCmd, mirrorRevB, sysResetReq, parkMute;
	logic power_on_sense, supply_good_warning, parkRequest, parkDone, bootStart;
	logic primary_pll_reset, systemReset, ioDriveEnable, cpuReset;
	logic normalPowerMode, cpuClockEnable, cpuClockFullRate;
	logic [OTHER_CLK_N-1:0] otherRelease, otherClockEnable, otherReset;
	int mismatches, nTests, n;

	power_up_reset_sequencer #(.LOCK_CYCLES(L)) dut (.clock(clock), .rst_n(rst_n),
		.power_on_sense(power_on_sense), .supply_good_warning(supply_good_warning),
		.mirrorRevB(mirrorRevB), .sysResetReq(sysResetReq), .parkRequest(parkRequest),
		.parkDone(parkDone), .otherRelease(otherRelease),
		.primary_pll_reset(primary_pll_reset), .systemReset(systemReset),
		.ioDriveEnable(ioDriveEnable), .normalPowerMode(normalPowerMode),
		.cpuClockEnable(cpuClockEnable), .cpuClockFullRate(cpuClockFullRate),
		.cpuReset(cpuReset), .otherClockEnable(otherClockEnable),
		.otherReset(otherReset), .bootStart(bootStart));
	power_monitor_model monitor (.clock(clock), .powerCmd(powerCmd), .warnCmd(warnCmd),
		.parkMute(parkMute),
		.parkRequest(parkRequest), .power_on_sense(power_on_sense),
		.supply_good_warning(supply_good_warning), .parkDone(parkDone));

	// Free-running 25 MHz timing reference; the lock count is the fixed shortened L, not scaled from its rate
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		nTests++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tick(input int k);
		repeat (k) @(negedge clock);
	endtask

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", nTests, mismatches);
		if (mismatches == 0 && nTests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Raise sense, then time the lock wait from the first edge that sees it
	task automatic power_up;
		@(posedge clock);
		powerCmd <= 1'b1;
		n = 0;
		while (power_on_sense !== 1'b1 && n < 20) begin
			@(negedge clock);
			n++;
		end
		@(negedge clock);
		check(primary_pll_reset, 1'b0);
		n = 1;
		while (systemReset !== 1'b0 && n < 100) begin
			@(negedge clock);
			n++;
		end
		check(n, L + 1);
		check({cpuReset, ioDriveEnable, bootStart}, 3'h3);
		check({normalPowerMode, cpuClockEnable, cpuClockFullRate}, 3'h7);
		check({otherClockEnable, otherReset}, 8'h0F);
		tick(1);
		check(bootStart, 1'b0);
	endtask

	// Hang guard, far beyond the roughly four hundred cycles the run needs
	initial begin
		#160000;
		mismatches++;
		complete_run();
	end

	initial begin
		{rst_n, powerCmd, warnCmd, mirrorRevB, sysResetReq, parkMute} = 6'h0;
		otherRelease = 4'h0;
		mismatches = 0;
		nTests = 0;
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		tick(5);
		check({systemReset, ioDriveEnable, primary_pll_reset}, 3'h5);
		power_up();
		// Firmware releases the other domains one at a time
		foreach (rows[i]) begin
			@(posedge clock);
			otherRelease <= rows[i].rel;
			@(posedge clock);
			otherRelease <= 4'h0;
			@(negedge clock);
			check({otherClockEnable, otherReset}, {rows[i].en, ~rows[i].en});
		end
		// System reset under power keeps the PLL and restores defaults
		@(posedge clock);
		sysResetReq <= 1'b1;
		tick(2);
		check({systemReset, primary_pll_reset, otherClockEnable}, 6'h20);
		@(posedge clock);
		sysResetReq <= 1'b0;
		tick(2);
		check({systemReset, cpuReset, bootStart, otherReset}, 7'h0F);
		// Supply warning parks the mirrors before reset is forced
		@(posedge clock);
		warnCmd <= 1'b1;
		tick(3);
		check({parkRequest, systemReset}, 2'h2);
		n = 0;
		while (systemReset !== 1'b1 && n < 300) begin
			@(negedge clock);
			n++;
		end
		check(n <= 8, 1'b1);
		@(posedge clock);
		warnCmd <= 1'b0;
		// A silent array must not hold off the reset; the park wait gives up
		tick(4);
		@(posedge clock);
		parkMute <= 1'b1;
		warnCmd <= 1'b1;
		n = 0;
		while (parkRequest !== 1'b1 && n < 20) begin
			@(negedge clock);
			n++;
		end
		n = 0;
		while (systemReset !== 1'b1 && n < 400) begin
			@(negedge clock);
			n++;
		end
		check(n, int'(PARK_TIMEOUT_CYCLES) + 1);
		@(posedge clock);
		warnCmd <= 1'b0;
		parkMute <= 1'b0;
		// Sense dropping forces full reset; the lock wait restarts
		@(posedge clock);
		powerCmd <= 1'b0;
		tick(3);
		check({systemReset, ioDriveEnable, cpuReset, primary_pll_reset}, 4'hB);
		// A drop in mid-lock must restart the wait from zero on the next rise
		@(posedge clock);
		powerCmd <= 1'b1;
		tick(10);
		check({systemReset, primary_pll_reset}, 2'h2);
		@(posedge clock);
		powerCmd <= 1'b0;
		tick(3);
		check({systemReset, primary_pll_reset}, 2'h3);
		power_up();
		// Revision B strap masks the warning
		@(posedge clock);
		rst_n <= 1'b0;
		mirrorRevB <= 1'b1;
		tick(3);
		check({systemReset, ioDriveEnable, otherReset}, 6'h2F);
		@(posedge clock);
		rst_n <= 1'b1;
		power_up();
		@(posedge clock);
		warnCmd <= 1'b1;
		tick(6);
		check({parkRequest, systemReset}, 2'h0);
		complete_run();
	end
endmodule
`default_nettype wire
